// >>> asc_pkg.sv
// package of constants and carrier types for the converter sequence control block
// =====================================================================
// Contract
// - resolution bit 10: zero gives 10-bit four channels, one gives 12-bit single
// - enable bit 15 runs the module; cleared holds it off
// - idle-stop bit 13 stops the module in idle, else it keeps running
// - build-order set: dma address equals the in-order stand-alone buffer address
// - build-order clear: dma address from input index and per-input buffer size
// - a dma request accompanies each setting of the converter interrupt flag
// - four-bit increment-rate field sets how often the dma pointer advances
// - 10-bit formats: integer, signed integer, fraction, signed fraction
// - 12-bit formats use same codes with inverted bit 11 as sign
// - trigger codes 001 pin edge, 010 timer compare, 011 pwm interval
// - code 111 internal counter converts, 000 software clear, 100-110 reserved
// - simultaneous bit samples four (1x) or two (01) channels together
// - in 12-bit mode the simultaneous bit reads zero
// - auto-sample set restarts sampling after each completed sequence, setting sample bit
// - sample bit samples while one; cleared by software or by the device
// - done bit set on finish; software writes only zero; no side effects
// - done bit cleared by device at start of each new conversion
// - bits 14, 11 and 4 ignore writes and read zero
// - field value n advances address or flags after every (n+1)th completed sequence
// - auto-convert samples for the five-bit sample-time field, 0 to 31 periods
package asc_pkg;
   // register offsets
   localparam logic [3:0] ASC_OFS_CON1 = 4'h0;
   localparam logic [3:0] ASC_OFS_CON2 = 4'h1;
   localparam logic [3:0] ASC_OFS_CON3 = 4'h2;
   localparam logic [3:0] ASC_OFS_CON4 = 4'h3;
   localparam logic [3:0] ASC_OFS_RES = 4'h4;
   localparam logic [3:0] ASC_OFS_STAT = 4'h5;
   // main control field positions
   localparam int ASC_B_EN = 15;
   localparam int ASC_B_IDLE = 13;
   localparam int ASC_B_DMABM = 12;
   localparam int ASC_B_RES = 10;
   localparam int ASC_B_FORM = 8;
   localparam int ASC_B_SSRC = 5;
   localparam int ASC_B_SIM = 3;
   localparam int ASC_B_AUTO_SAMPLE_START = 2;
   localparam int ASC_B_SAMPLE_ACTIVE = 1;
   localparam int ASC_B_DONE = 0;
   localparam logic [15:0] ASC_CON1_WMASK = 16'hb7ee;
   localparam logic [15:0] ASC_CON2_WMASK = 16'h033c;
   localparam logic [15:0] ASC_CON3_WMASK = 16'h1f00;
   localparam logic [15:0] ASC_CON4_WMASK = 16'h0007;
   localparam logic [15:0] ASC_REG_RESET = 16'h0000;
   // second/third control field positions
   localparam int ASC_B_CHPS = 8;
   localparam int ASC_B_SMPI = 2;
   localparam int ASC_B_SAMC = 8;
   // trigger source codes
   localparam logic [2:0] ASC_TRG_SW = 3'h0;
   localparam logic [2:0] ASC_TRG_PIN = 3'h1;
   localparam logic [2:0] ASC_TRG_TMR = 3'h2;
   localparam logic [2:0] ASC_TRG_PWM = 3'h3;
   localparam logic [2:0] ASC_TRG_AUTO = 3'h7;
   // sequencer states
   typedef enum logic [2:0] {
      ASC_ST_IDLE = 3'b001,
      ASC_ST_SAMPLE = 3'b010,
      ASC_ST_CONVERT = 3'b100
   } asc_state_t;
   // converter request and answer
   typedef struct packed {
      logic start;
      logic [1:0] channel;
   } asc_conv_req_t;
   typedef struct packed {
      logic done;
      logic [11:0] result;
   } asc_conv_ans_t;
   // dma request toward the channel
   typedef struct packed {
      logic req;
      logic [15:0] addr;
      logic [15:0] data;
   } asc_dma_t;
endpackage

// >>> asc_seq_ctrl.sv
// converter sequence control: registers, trigger, sequencing, formatting, dma addresses
`timescale 1ns/1ns
module asc_seq_ctrl
   import asc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // device state and trigger sources
   input wire logic cpu_idle,
   input wire logic external_irq_pin,
   input wire logic timer_compare,
   input wire logic motor_pwm_interval,
   input wire logic tad_tick,
   // analog converter
   output asc_conv_req_t conv_req,
   input wire asc_conv_ans_t conv_ans,
   // dma channel and flag
   output asc_dma_t dma_out,
   output logic converter_irq_flag
);
   // =====================================================================
   // registers
   logic [15:0] con1, con2, con3, con4;
   logic [15:0] result_word;
   logic [15:0] next_con1;
   asc_state_t state, next_state;
   logic [4:0] sample_cnt;
   logic [3:0] conv_count;
   logic [1:0] chan_idx;
   logic [15:0] dma_ptr;
   logic pin_s1, pin_s2, pin_prev;
   logic run, trig, start_conv, finish, rate_hit;
   logic sw_end;

   // 12-bit mode: simultaneous and channel count bits are unimplemented
   function automatic logic [15:0] view_con1(input logic [15:0] v);
      logic [15:0] r;
      r = v;
      if (v[ASC_B_RES])
         r[ASC_B_SIM] = 1'b0;
      return r;
   endfunction

   // result formatting for both resolutions
   function automatic logic [15:0] fmt(input logic [11:0] d, input logic [1:0] f,
                                       input logic hi);
      logic [15:0] r;
      r = 16'h0000;
      if (!hi) begin
         unique case (f)
            2'h0: r = {6'h00, d[9:0]};
            2'h1: r = {{6{~d[9]}}, ~d[9], d[8:0]};
            2'h2: r = {d[9:0], 6'h00};
            2'h3: r = {~d[9], d[8:0], 6'h00};
         endcase
      end else begin
         unique case (f)
            2'h0: r = {4'h0, d};
            2'h1: r = {{4{~d[11]}}, ~d[11], d[10:0]};
            2'h2: r = {d, 4'h0};
            2'h3: r = {~d[11], d[10:0], 4'h0};
         endcase
      end
      return r;
   endfunction

   // number of channels taken in one sequence, minus one
   function automatic logic [1:0] last_chan(input logic [15:0] c1, input logic [15:0] c2);
      logic [1:0] r;
      r = 2'h0;
      if (!c1[ASC_B_RES]) begin
         if (c2[ASC_B_CHPS+1])
            r = 2'h3;
         else if (c2[ASC_B_CHPS])
            r = 2'h1;
      end
      return r;
   endfunction

   // =====================================================================
   // pin synchroniser and trigger selection
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         pin_prev <= 1'b0;
      end else if (clk_en) begin
         pin_s1 <= external_irq_pin;
         pin_s2 <= pin_s1;
         pin_prev <= pin_s2;
      end
   end

   assign run = con1[ASC_B_EN] && !(con1[ASC_B_IDLE] && cpu_idle);
   assign sw_end = reg_wr && reg_addr == ASC_OFS_CON1 && !reg_wdata[ASC_B_SAMPLE_ACTIVE];

   always_comb begin
      trig = 1'b0;
      unique case (con1[ASC_B_SSRC +: 3])
         ASC_TRG_SW: trig = sw_end;
         ASC_TRG_PIN: trig = pin_s2 && !pin_prev;
         ASC_TRG_TMR: trig = timer_compare;
         ASC_TRG_PWM: trig = motor_pwm_interval;
         ASC_TRG_AUTO: trig = sample_cnt >= con3[ASC_B_SAMC +: 5];
         default: trig = 1'b0;
      endcase
   end

   assign start_conv = run && state == ASC_ST_SAMPLE && trig;
   assign finish = state == ASC_ST_CONVERT && conv_ans.done;
   assign rate_hit = finish && chan_idx == last_chan(con1, con2)
                     && conv_count == con2[ASC_B_SMPI +: 4];

   // =====================================================================
   // sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         ASC_ST_IDLE:
            if (run && con1[ASC_B_SAMPLE_ACTIVE])
               next_state = ASC_ST_SAMPLE;
         ASC_ST_SAMPLE:
            if (!run)
               next_state = ASC_ST_IDLE;
            else if (start_conv)
               next_state = ASC_ST_CONVERT;
         ASC_ST_CONVERT:
            if (!con1[ASC_B_EN])
               next_state = ASC_ST_IDLE;
            else if (finish && chan_idx == last_chan(con1, con2))
               next_state = con1[ASC_B_AUTO_SAMPLE_START] ? ASC_ST_SAMPLE : ASC_ST_IDLE;
            else if (finish && con1[ASC_B_SIM])
               next_state = ASC_ST_CONVERT;
            else if (finish)
               next_state = ASC_ST_SAMPLE;
         default: next_state = ASC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         state <= ASC_ST_IDLE;
      else if (clk_en)
         state <= next_state;
   end

   // auto-convert sample timer counts conversion clock periods
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         sample_cnt <= 5'h00;
      else if (clk_en) begin
         if (state != ASC_ST_SAMPLE)
            sample_cnt <= 5'h00;
         else if (tad_tick && sample_cnt != 5'h1f)
            sample_cnt <= sample_cnt + 5'h01;
      end
   end

   // channel index within a sequence, completed-sequence count within a rate group
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         chan_idx <= 2'h0;
         conv_count <= 4'h0;
      end else if (clk_en) begin
         if (!con1[ASC_B_EN]) begin
            chan_idx <= 2'h0;
            conv_count <= 4'h0;
         end else if (finish) begin
            if (chan_idx == last_chan(con1, con2)) begin
               chan_idx <= 2'h0;
               conv_count <= rate_hit ? 4'h0 : conv_count + 4'h1;
            end else
               chan_idx <= chan_idx + 2'h1;
         end
      end
   end

   // =====================================================================
   // main control register with hardware set/clear of sample and done
   always_comb begin
      next_con1 = con1;
      if (reg_wr && reg_addr == ASC_OFS_CON1) begin
         next_con1 = (con1 & ~ASC_CON1_WMASK) | (reg_wdata & ASC_CON1_WMASK);
         if (!reg_wdata[ASC_B_DONE])
            next_con1[ASC_B_DONE] = 1'b0;
         if (con1[ASC_B_EN] && reg_wdata[ASC_B_RES] != con1[ASC_B_RES])
            next_con1[ASC_B_RES] = con1[ASC_B_RES];
      end
      if (start_conv) begin
         next_con1[ASC_B_SAMPLE_ACTIVE] = 1'b0;
         next_con1[ASC_B_DONE] = 1'b0;
      end
      if (finish && chan_idx == last_chan(con1, con2)) begin
         next_con1[ASC_B_DONE] = 1'b1;
         if (con1[ASC_B_AUTO_SAMPLE_START])
            next_con1[ASC_B_SAMPLE_ACTIVE] = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         con1 <= ASC_REG_RESET;
      else if (clk_en)
         con1 <= next_con1;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         con2 <= ASC_REG_RESET;
         con3 <= ASC_REG_RESET;
         con4 <= ASC_REG_RESET;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == ASC_OFS_CON2)
            con2 <= reg_wdata & ASC_CON2_WMASK;
         if (reg_addr == ASC_OFS_CON3)
            con3 <= reg_wdata & ASC_CON3_WMASK;
         if (reg_addr == ASC_OFS_CON4)
            con4 <= reg_wdata & ASC_CON4_WMASK;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         reg_rdata <= 16'h0000;
      else if (clk_en) begin
         reg_rdata <= 16'h0000;
         if (reg_rd) begin
            unique case (reg_addr)
               ASC_OFS_CON1: reg_rdata <= view_con1(con1);
               ASC_OFS_CON2: reg_rdata <= con1[ASC_B_RES] ? con2 & 16'hfcff : con2;
               ASC_OFS_CON3: reg_rdata <= con3;
               ASC_OFS_CON4: reg_rdata <= con4;
               ASC_OFS_RES: reg_rdata <= result_word;
               ASC_OFS_STAT: reg_rdata <= {13'h0000, state};
               default: reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // =====================================================================
   // converter start pulse and result capture
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         conv_req <= '0;
      else if (clk_en) begin
         conv_req.start <= start_conv || (finish && con1[ASC_B_SIM]
                           && chan_idx != last_chan(con1, con2));
         conv_req.channel <= start_conv ? chan_idx : chan_idx + 2'h1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         result_word <= 16'h0000;
      else if (clk_en && finish)
         result_word <= fmt(conv_ans.result, con1[ASC_B_FORM +: 2], con1[ASC_B_RES]);
   end

   // =====================================================================
   // dma address, request and interrupt flag
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         dma_ptr <= 16'h0000;
      else if (clk_en) begin
         if (!con1[ASC_B_EN])
            dma_ptr <= 16'h0000;
         else if (rate_hit)
            dma_ptr <= dma_ptr + 16'h0001;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dma_out <= '0;
         converter_irq_flag <= 1'b0;
      end else if (clk_en) begin
         dma_out.req <= finish;
         converter_irq_flag <= rate_hit;
         if (finish) begin
            dma_out.data <= fmt(conv_ans.result, con1[ASC_B_FORM +: 2], con1[ASC_B_RES]);
            if (con1[ASC_B_DMABM])
               dma_out.addr <= dma_ptr + {12'h000, 2'h0, chan_idx};
            else
               dma_out.addr <= ({14'h0000, chan_idx} << con4[2:0]) + dma_ptr;
         end
      end
   end

   // =====================================================================
   // checks
   done_sets_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && finish && chan_idx == last_chan(con1, con2) |=> con1[ASC_B_DONE])
      else $error("done not set after sequence");
   start_clears_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && start_conv |=> !con1[ASC_B_DONE] && !con1[ASC_B_SAMPLE_ACTIVE])
      else $error("start did not clear flags");
   unimpl_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      con1[14] == 1'b0 && con1[11] == 1'b0 && con1[4] == 1'b0)
      else $error("unimplemented bit set");
   off_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && !con1[ASC_B_EN] |=> state == ASC_ST_IDLE)
      else $error("sequencer ran while off");
   auto_resample_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && finish && chan_idx == last_chan(con1, con2) && con1[ASC_B_AUTO_SAMPLE_START]
      && con1[ASC_B_EN] |=> con1[ASC_B_SAMPLE_ACTIVE])
      else $error("auto sample not restarted");
   res_locked_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && con1[ASC_B_EN] |=> $stable(con1[ASC_B_RES]))
      else $error("resolution changed while on");
   start_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && start_conv |=> conv_req.start)
      else $error("no converter start");
   dma_req_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && finish |=> dma_out.req)
      else $error("no dma request");
   sim_hidden_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == ASC_OFS_CON1 && con1[ASC_B_RES] |=> !reg_rdata[ASC_B_SIM])
      else $error("simultaneous bit visible in 12-bit mode");
   irq_rate_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && rate_hit |=> converter_irq_flag)
      else $error("no flag pulse at group end");
   ptr_step_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && rate_hit && con1[ASC_B_EN] |=> dma_ptr == $past(dma_ptr) + 16'h0001)
      else $error("dma pointer did not advance");
   done_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && !con1[ASC_B_DONE] && !(finish && chan_idx == last_chan(con1, con2))
      |=> !con1[ASC_B_DONE])
      else $error("done set without a finished sequence");
   trig_reserved_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && con1[ASC_B_SSRC +: 3] inside {3'h4, 3'h5, 3'h6} |-> !start_conv)
      else $error("reserved trigger started a conversion");
   addr_order_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && finish && con1[ASC_B_DMABM]
      |=> dma_out.addr == $past(dma_ptr) + {14'h0000, $past(chan_idx)})
      else $error("in-order dma address wrong");
endmodule // asc_seq_ctrl

// >>> asc_conv_model.sv
// far-side model: analog converter answering start pulses, dma channel and flag capture
`timescale 1ns/1ns
module asc_conv_model
   import asc_pkg::*;
#(
   parameter int DLY = 3
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // converter side
   input wire asc_conv_req_t conv_req,
   output asc_conv_ans_t conv_ans,
   input wire logic [11:0] raw,
   // dma side and flag
   input wire asc_dma_t dma_out,
   input wire logic converter_irq_flag,
   // observations
   output logic [7:0] n_start,
   output logic [7:0] n_dma,
   output logic [7:0] n_irq,
   output logic [1:0] last_chan,
   output logic [15:0] last_addr,
   output logic [15:0] prev_addr,
   output logic [15:0] last_data
);
   logic [3:0] cnt;
   logic busy;
   // =========================================================
   // converter
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         conv_ans <= '0;
         n_start <= 8'h00;
         last_chan <= 2'h0;
      end else begin
         conv_ans.done <= 1'b0;
         // result lines toggle outside the done cycle
         conv_ans.result <= ~conv_ans.result;
         if (conv_req.start) begin
            busy <= 1'b1;
            cnt <= 4'(DLY);
            n_start <= n_start + 8'h01;
            last_chan <= conv_req.channel;
         end else if (busy) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
               busy <= 1'b0;
               conv_ans.done <= 1'b1;
               conv_ans.result <= raw;
            end
         end
      end
   end
   // =========================================================
   // dma channel
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         n_dma <= 8'h00;
         n_irq <= 8'h00;
         last_addr <= 16'h0000;
         prev_addr <= 16'h0000;
         last_data <= 16'h0000;
      end else begin
         if (dma_out.req) begin
            n_dma <= n_dma + 8'h01;
            prev_addr <= last_addr;
            last_addr <= dma_out.addr;
            last_data <= dma_out.data;
         end
         if (converter_irq_flag) begin
            n_irq <= n_irq + 8'h01;
         end
      end
   end
endmodule // asc_conv_model

// >>> test_asc_seq_ctrl.sv
// testbench of the converter sequence control block
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_asc_seq_ctrl
   import asc_pkg::*;
;
   logic clk, sys_rst, reg_wr, reg_rd, cpu_idle, tad_tick, irq;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, last_addr, prev_addr, last_data, rd_v, c, ex;
   logic [2:0] trg_v;
   logic [11:0] raw;
   logic [7:0] n_start, n_dma, n_irq, e_dma, ei;
   logic [1:0] last_chan;
   asc_conv_req_t conv_req;
   asc_conv_ans_t conv_ans;
   asc_dma_t dma_out;
   int n_mismatch, compares, m, f, k;
   logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
   asc_seq_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cpu_idle(cpu_idle), .external_irq_pin(trg_v[0]), .timer_compare(trg_v[1]),
      .motor_pwm_interval(trg_v[2]), .tad_tick(tad_tick), .conv_req(conv_req),
      .conv_ans(conv_ans), .dma_out(dma_out), .converter_irq_flag(irq));
   asc_conv_model i_conv (.clk(clk), .sys_rst(sys_rst), .conv_req(conv_req),
      .conv_ans(conv_ans), .raw(raw), .dma_out(dma_out), .converter_irq_flag(irq),
      .n_start(n_start), .n_dma(n_dma), .n_irq(n_irq), .last_chan(last_chan),
      .last_addr(last_addr), .prev_addr(prev_addr), .last_data(last_data));
   // =========================================================
   // clock and tasks
   always #25 clk = ~clk;
   always @(posedge clk) tad_tick <= ~tad_tick;
   task wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk); reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input logic [3:0] a);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk); reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
      @(posedge clk);
   endtask
   task wait_n(input logic [7:0] n, input int use_dma);
      int i;
      for (i = 0; i < 100; i++) begin
         if ((use_dma != 0 ? n_dma : n_start) === n) break;
         @(posedge clk);
      end
      if (i == 100) n_mismatch++;
      repeat (2) @(posedge clk);
   endtask
   task pulse(input logic [2:0] v, input int n);
      trg_v <= v;
      repeat (n) @(posedge clk);
      trg_v <= 3'h0;
      @(posedge clk);
   endtask
   // software-triggered sequence producing n results
   task conv(input logic [15:0] cc, input logic [7:0] n);
      wr(ASC_OFS_CON1, cc | 16'h0002);
      wr(ASC_OFS_CON1, cc);
      e_dma = e_dma + n;
      wait_n(e_dma, 1);
   endtask
   function automatic logic [15:0] fx(input logic r12, input logic [1:0] fm, input logic [11:0] r);
      if (!r12) begin
         case (fm)
            2'h0: fx = {6'h00, r[9:0]};
            2'h1: fx = {{7{~r[9]}}, r[8:0]};
            2'h2: fx = {r[9:0], 6'h00};
            default: fx = {~r[9], r[8:0], 6'h00};
         endcase
      end else begin
         case (fm)
            2'h0: fx = {4'h0, r};
            2'h1: fx = {{5{~r[11]}}, r[10:0]};
            2'h2: fx = {r, 4'h0};
            default: fx = {~r[11], r[10:0], 4'h0};
         endcase
      end
   endfunction
   task tally_and_finish;
      $display("mismatches %0d of %0d compares", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      n_mismatch++;
      tally_and_finish();
   end
   // =========================================================
   // tests
   initial begin
      clk = 1'b0; sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
      reg_wdata = 16'h0000; cpu_idle = 1'b0; tad_tick = 1'b0; trg_v = 3'h0; raw = 12'h000;
      n_mismatch = 0; compares = 0; e_dma = 8'h00;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(ASC_OFS_CON1); `CHK(rd_v, 16'h0000)
      rd(ASC_OFS_STAT); `CHK(rd_v, 16'h0001)
      wr(ASC_OFS_CON1, 16'h7ff8); rd(ASC_OFS_CON1); `CHK(rd_v, 16'h37e0)
      wr(ASC_OFS_CON1, 16'h3be8); rd(ASC_OFS_CON1); `CHK(rd_v, 16'h33e8)
      wr(ASC_OFS_CON1, 16'h8000); wr(ASC_OFS_CON1, 16'h8400);
      rd(ASC_OFS_CON1); `CHK(rd_v, 16'h8000)
      for (m = 0; m < 2; m++) begin
         for (f = 0; f < 4; f++) begin
            c = 16'h8000 | 16'(m << 10) | 16'(f << 8);
            wr(ASC_OFS_CON1, c & 16'h7fff);
            raw <= (m != 0) ? 12'h8a5 : 12'h2a5;
            conv(c, 8'h01);
            `CHK(last_data, fx(m[0], f[1:0], raw))
            rd(ASC_OFS_RES); `CHK(rd_v, fx(m[0], f[1:0], raw))
            rd(ASC_OFS_CON1); `CHK(rd_v, c | 16'h0001)
         end
      end
      wr(ASC_OFS_CON1, 16'h0001);
      wr(ASC_OFS_CON3, 16'h0200);
      for (k = 0; k < 4; k++) begin
         c = 16'h8000 | {8'h00, codes[k], 5'h00};
         wr(ASC_OFS_CON1, c | 16'h0003);
         if (codes[k] != 3'h7) pulse(3'h1 << (codes[k] - 3'h1), (codes[k] == 3'h1) ? 4 : 1);
         wait_n(e_dma + 8'h01, 0);
         rd(ASC_OFS_CON1); `CHK(rd_v, c)
         e_dma = e_dma + 8'h01;
         wait_n(e_dma, 1);
         rd(ASC_OFS_CON1); `CHK(rd_v, c | 16'h0001)
      end
      wr(ASC_OFS_CON1, 16'h8000); rd(ASC_OFS_CON1); `CHK(rd_v, 16'h8000)
      wr(ASC_OFS_CON1, 16'h8001); rd(ASC_OFS_CON1); `CHK(rd_v, 16'h8000)
      wr(ASC_OFS_CON1, 16'h8082); pulse(3'h7, 4); repeat (10) @(posedge clk);
      `CHK(n_start, e_dma)
      wr(ASC_OFS_CON1, 16'h0000); wr(ASC_OFS_CON1, 16'ha022); cpu_idle <= 1'b1;
      pulse(3'h1, 4); repeat (10) @(posedge clk);
      `CHK(n_start, e_dma)
      wr(ASC_OFS_CON1, 16'h0022); pulse(3'h1, 4); repeat (10) @(posedge clk);
      `CHK(n_start, e_dma)
      wr(ASC_OFS_CON1, 16'h8022); pulse(3'h1, 4);
      e_dma = e_dma + 8'h01; wait_n(e_dma, 1);
      `CHK(n_dma, e_dma)
      cpu_idle <= 1'b0;
      wr(ASC_OFS_CON1, 16'h0000); conv(16'h8004, 8'h01);
      rd(ASC_OFS_CON1); `CHK(rd_v, 16'h8007)
      wr(ASC_OFS_CON1, 16'h0000); wr(ASC_OFS_CON2, 16'h0004);
      ei = n_irq;
      conv(16'h8000, 8'h01); `CHK(n_irq, ei)
      conv(16'h8000, 8'h01); `CHK(n_irq, ei + 8'h01)
      wr(ASC_OFS_CON1, 16'h0000); wr(ASC_OFS_CON2, 16'h0100); wr(ASC_OFS_CON4, 16'h0003);
      conv(16'h8008, 8'h02); `CHK(last_chan, 2'h1)
      ex = last_addr - prev_addr; `CHK(ex, 16'h0008)
      wr(ASC_OFS_CON1, 16'h0000); conv(16'h9008, 8'h02);
      ex = last_addr - prev_addr; `CHK(ex, 16'h0001)
      // sequential two-channel: the second channel waits for its own trigger
      wr(ASC_OFS_CON1, 16'h0000); conv(16'h8000, 8'h01);
      wr(ASC_OFS_CON1, 16'h8000); e_dma = e_dma + 8'h01; wait_n(e_dma, 1);
      `CHK(last_chan, 2'h1)
      ex = last_addr - prev_addr; `CHK(ex, 16'h0008)
      `CHK(n_dma, e_dma)
      tally_and_finish();
   end
endmodule // test_asc_seq_ctrl
